// >>> coeff_master.sv
// Coefficient port master model with its own slower bus clock.
// Assumes the bench calls its tasks one at a time.
`timescale 1ns/10ps
module coeff_master (
	output logic              clk_out,
	output logic              rst_out,
	output logic [6:0]        addr_out,
	output logic [15:0]       wdata_out,
	output logic              we_out,
	input  wire logic [15:0]  rdata_in,
	input  wire logic         rvalid_in
);
	// Free running bus clock, 4 MHz
	initial begin
		clk_out = 1'b0;
		forever #125 clk_out = ~clk_out;
	end

	// Port held in reset until the first set
	initial begin
		rst_out = 1'b1;
		addr_out = 7'h00;
		wdata_out = 16'h0000;
		we_out = 1'b0;
	end

	// Reset pulse ahead of a new set
	task automatic pulse_rst();
		@(negedge clk_out) rst_out = 1'b1;
		@(negedge clk_out) rst_out = 1'b0;
	endtask

	// One address and word per cycle, enable held
	task automatic wr(input logic [6:0] a, input logic [15:0] dat);
		@(negedge clk_out);
		we_out = 1'b1;
		addr_out = a;
		wdata_out = dat;
	endtask

	// End of burst; data lines no longer meaningful
	task automatic wr_end();
		@(negedge clk_out);
		we_out = 1'b0;
		wdata_out = ~wdata_out;
	endtask

	// Address one cycle, answer taken a cycle on
	task automatic rd(input logic [6:0] a, output logic [15:0] dat, output logic vld);
		@(negedge clk_out) addr_out = a;
		@(negedge clk_out);
		dat = rdata_in;
		vld = rvalid_in;
	endtask
endmodule // coeff_master

// >>> fir_bank_checker_assertions.sv
// Checker for the stream FIFO and coefficient read port of the bank block.
// Assumes binding onto the top module; watches its ports only.
`timescale 1ns/10ps
module fir_bank_checker #(
	parameter int  INPUT_WIRE_COUNT = 1,
	parameter int  SAMPLE_W         = 8,
	parameter int  BANK_COUNT       = 4,
	parameter int  TAPS             = 37,
	parameter int  SYMMETRIC        = 1,
	parameter int  COEFF_W          = 16,
	parameter int  FIFO_DEPTH       = 32,
	localparam int BANK_W           = (BANK_COUNT > 1) ? $clog2(BANK_COUNT) : 1,
	localparam int LANE_W           = SAMPLE_W + BANK_W,
	localparam int PER_BANK         = (SYMMETRIC != 0) ? (TAPS + 1) / 2 : TAPS,
	localparam int TOTAL            = PER_BANK * BANK_COUNT,
	localparam int ADDR_W           = (TOTAL > 1) ? $clog2(TOTAL) : 1
) (
	input wire logic                                 sys_clk_in,
	input wire logic                                 nrst_in,
	input wire logic                                 sink_valid_in,
	input wire logic                                 sink_ready_out,
	input wire logic [LANE_W*INPUT_WIRE_COUNT-1:0]   sink_data_in,
	input wire logic                                 out_valid_out,
	input wire logic                                 out_ready_in,
	input wire logic [SAMPLE_W*INPUT_WIRE_COUNT-1:0] out_sample_out,
	input wire logic [BANK_W*INPUT_WIRE_COUNT-1:0]   out_bank_out,
	input wire logic                                 coeff_clk_in,
	input wire logic                                 coeff_rst_in,
	input wire logic [ADDR_W-1:0]                    coeff_addr_in,
	input wire logic                                 coeff_we_in,
	input wire logic [COEFF_W-1:0]                   coeff_rdata_out,
	input wire logic                                 coeff_rvalid_out
);
	int occ;

	// Occupancy seen from the two handshakes
	always_ff @(posedge sys_clk_in or negedge nrst_in) begin
		if (!nrst_in)
			occ <= 0;
		else
			occ <= occ + int'(sink_valid_in && sink_ready_out) - int'(out_valid_out && out_ready_in);
	end

	AST_FULL: assert property (@(posedge sys_clk_in) disable iff (!nrst_in)
		sink_ready_out == (occ < FIFO_DEPTH)) else $error("ready does not match fill level");
	AST_EMPTY: assert property (@(posedge sys_clk_in) disable iff (!nrst_in)
		out_valid_out == (occ != 0)) else $error("valid does not match fill level");
	AST_HOLD: assert property (@(posedge sys_clk_in) disable iff (!nrst_in)
		out_valid_out && !out_ready_in |=> $stable(out_sample_out) && $stable(out_bank_out))
		else $error("head changed while stalled");
	AST_PASS: assert property (@(posedge sys_clk_in) disable iff (!nrst_in)
		sink_valid_in && sink_ready_out && !out_valid_out |=> out_valid_out
		&& out_sample_out[SAMPLE_W-1:0] == $past(sink_data_in[SAMPLE_W-1:0])
		&& out_bank_out[BANK_W-1:0] == $past(sink_data_in[LANE_W-1 -: BANK_W]))
		else $error("wire 0 split wrong");
	AST_RD_WE: assert property (@(posedge coeff_clk_in) disable iff (coeff_rst_in)
		coeff_we_in |=> !coeff_rvalid_out) else $error("read valid during write");
	AST_RD_RANGE: assert property (@(posedge coeff_clk_in) disable iff (coeff_rst_in)
		!coeff_we_in && coeff_addr_in >= TOTAL |=> !coeff_rvalid_out) else $error("valid outside range");
	AST_RD_OK: assert property (@(posedge coeff_clk_in) disable iff (coeff_rst_in)
		!coeff_we_in && coeff_addr_in < TOTAL |=> coeff_rvalid_out) else $error("read not answered");
	AST_RD_ZERO: assert property (@(posedge coeff_clk_in) disable iff (coeff_rst_in)
		!coeff_rvalid_out |-> coeff_rdata_out == '0) else $error("data without valid");
endmodule // fir_bank_checker

bind fir_coeff_bank_reload fir_bank_checker #(.INPUT_WIRE_COUNT(INPUT_WIRE_COUNT), .SAMPLE_W(SAMPLE_W),
	.BANK_COUNT(BANK_COUNT), .TAPS(TAPS), .SYMMETRIC(SYMMETRIC), .COEFF_W(COEFF_W), .FIFO_DEPTH(FIFO_DEPTH))
	chk (.sys_clk_in, .nrst_in, .sink_valid_in, .sink_ready_out, .sink_data_in, .out_valid_out, .out_ready_in,
	.out_sample_out, .out_bank_out, .coeff_clk_in, .coeff_rst_in, .coeff_addr_in, .coeff_we_in,
	.coeff_rdata_out, .coeff_rvalid_out);

// >>> fir_bank_pkg.sv
// Types shared by the coefficient bank and reload block.
// Assumes the constants header sits in the same folder.
`include "fir_bank_regs.svh"

package fir_bank_pkg;

	// One decoded coefficient port write
	typedef struct packed {
		logic                             we;
		logic [`FIR_CARRIER_ADDR_W-1:0]   addr;
		logic [`FIR_CARRIER_DATA_W-1:0]   data;
	} coeff_wr_t;

	// One coefficient port read answer
	typedef struct packed {
		logic                             valid;
		logic [`FIR_CARRIER_DATA_W-1:0]   data;
	} coeff_rd_t;

endpackage

// >>> fir_bank_regs.svh
// Constants for the coefficient bank and reload block.
// Assumes inclusion by bare name from the package and the design file.
`ifndef FIR_BANK_REGS_SVH
`define FIR_BANK_REGS_SVH

// Coefficient write data port widths
`define FIR_WDATA_NARROW_W   16
`define FIR_WDATA_WIDE_W     32
`define FIR_WDATA_NARROW_MAX 16

// Carrier field widths
`define FIR_CARRIER_ADDR_W   16
`define FIR_CARRIER_DATA_W   32

// Reset values
`define FIR_RST_TOGGLE       1'b0
`define FIR_RST_RVALID       1'b0
`define FIR_RST_SYNC         3'h0

`endif

// >>> fir_coeff_bank_reload.sv
// Bank-select and run-time coefficient reload logic of a FIR filter, plus its input FIFO.
// Assumes an upstream stream source, a coefficient master on its own clock, and an
// arithmetic engine downstream that walks tap_index_in while consuming each sample.
`timescale 1ns/10ps

`include "fir_bank_regs.svh"

// Synchronous FIFO held in flip-flops
module stream_fifo #(
	parameter int WIDTH = 10,
	parameter int DEPTH = 32
) (
	input  wire logic             sys_clk_in,
	input  wire logic             rst_n_in,
	input  wire logic             in_valid_in,
	output logic                  in_ready_out,
	input  wire logic [WIDTH-1:0] in_data_in,
	output logic                  out_valid_out,
	input  wire logic             out_ready_in,
	output logic      [WIDTH-1:0] out_data_out
);
	localparam int PTR_W = (DEPTH > 1) ? $clog2(DEPTH) : 1;
	localparam int CNT_W = $clog2(DEPTH + 1);
	localparam logic [CNT_W-1:0] FULL_CNT = CNT_W'(DEPTH);
	localparam logic [PTR_W-1:0] LAST_PTR = PTR_W'(DEPTH - 1);

	logic [WIDTH-1:0] mem [DEPTH];
	logic [PTR_W-1:0] wr_ptr;
	logic [PTR_W-1:0] rd_ptr;
	logic [CNT_W-1:0] count;
	wire              push;
	wire              pop;
	wire  [PTR_W-1:0] next_wr_ptr;
	wire  [PTR_W-1:0] next_rd_ptr;

	// Honest full and empty from the fill count
	assign in_ready_out  = (count != FULL_CNT);
	assign out_valid_out = (count != '0);
	assign push          = in_valid_in && in_ready_out;
	assign pop           = out_valid_out && out_ready_in;
	assign out_data_out  = mem[rd_ptr];

	// Pointer steps wrap at the depth
	assign next_wr_ptr = (wr_ptr == LAST_PTR) ? '0 : wr_ptr + 1'b1;
	assign next_rd_ptr = (rd_ptr == LAST_PTR) ? '0 : rd_ptr + 1'b1;

	// Storage slots cleared by reset, so the head is never unknown
	genvar s;
	generate
		for (s = 0; s < DEPTH; s++) begin : g_slot
			wire slot_hit;
			assign slot_hit = push && (wr_ptr == PTR_W'(s));
			always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
				if (!rst_n_in) begin
					mem[s] <= '0;
				end else if (slot_hit) begin
					mem[s] <= in_data_in;
				end
			end
		end
	endgenerate

	// Write pointer
	always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			wr_ptr <= '0;
		end else if (push) begin
			wr_ptr <= next_wr_ptr;
		end
	end

	// Read pointer
	always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			rd_ptr <= '0;
		end else if (pop) begin
			rd_ptr <= next_rd_ptr;
		end
	end

	// Fill count
	always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			count <= '0;
		end else if (push && !pop) begin
			count <= count + 1'b1;
		end else if (pop && !push) begin
			count <= count - 1'b1;
		end
	end
endmodule // stream_fifo

// Bank select, coefficient storage and reload port
module fir_coeff_bank_reload #(
	parameter int INPUT_WIRE_COUNT = 1,
	parameter int SAMPLE_W         = 8,
	parameter int BANK_COUNT       = 4,
	parameter int TAPS             = 37,
	parameter int SYMMETRIC        = 1,
	parameter int COEFF_W          = 16,
	parameter int RELOAD_EN        = 1,
	parameter int READ_WRITE       = 1,
	parameter int BACKPRESSURE     = 1,
	parameter int FIFO_DEPTH       = 32,
	localparam int BANK_W   = (BANK_COUNT > 1) ? $clog2(BANK_COUNT) : 1,
	localparam int LANE_W   = SAMPLE_W + BANK_W,
	localparam int SINK_W   = LANE_W * INPUT_WIRE_COUNT,
	localparam int PER_BANK = (SYMMETRIC != 0) ? (TAPS + 1) / 2 : TAPS,
	localparam int TOTAL    = PER_BANK * BANK_COUNT,
	localparam int ADDR_W   = (TOTAL > 1) ? $clog2(TOTAL) : 1,
	localparam int TAP_W    = (TAPS > 1) ? $clog2(TAPS) : 1,
	localparam int WDATA_W  = (COEFF_W <= `FIR_WDATA_NARROW_MAX) ? `FIR_WDATA_NARROW_W : `FIR_WDATA_WIDE_W
) (
	input  wire logic                                sys_clk_in,
	input  wire logic                                nrst_in,
	input  wire logic                                sink_valid_in,
	output logic                                     sink_ready_out,
	input  wire logic [SINK_W-1:0]                   sink_data_in,
	output logic                                     out_valid_out,
	input  wire logic                                out_ready_in,
	output logic      [SAMPLE_W*INPUT_WIRE_COUNT-1:0] out_sample_out,
	output logic      [BANK_W*INPUT_WIRE_COUNT-1:0]  out_bank_out,
	input  wire logic [TAP_W-1:0]                    tap_index_in,
	output logic      [COEFF_W*INPUT_WIRE_COUNT-1:0] tap_coeff_out,
	input  wire logic                                coeff_clk_in,
	input  wire logic                                coeff_rst_in,
	input  wire logic [ADDR_W-1:0]                   coeff_addr_in,
	input  wire logic [WDATA_W-1:0]                  coeff_wdata_in,
	input  wire logic                                coeff_we_in,
	output logic      [COEFF_W-1:0]                  coeff_rdata_out,
	output logic                                     coeff_rvalid_out
);
	localparam logic [ADDR_W:0]  TOTAL_A   = (ADDR_W + 1)'(TOTAL);
	localparam logic [TAP_W:0]   PER_BANK_T = (TAP_W + 1)'(PER_BANK);
	localparam logic [TAP_W:0]   TAPS_LAST  = (TAP_W + 1)'(TAPS - 1);

	// Address inside the coefficient space
	function automatic logic addr_in_range(input logic [ADDR_W-1:0] a);
		addr_in_range = ({1'b0, a} < TOTAL_A);
	endfunction

	// Storage index of a tap within a bank; mirrored taps share a word
	function automatic logic [ADDR_W-1:0] tap_word(input logic [BANK_W-1:0] bank,
	                                               input logic [TAP_W-1:0] tap);
		logic [TAP_W:0]  t;
		logic [31:0]     idx;
		t = {1'b0, tap};
		if ((SYMMETRIC != 0) && (t >= PER_BANK_T)) begin
			t = TAPS_LAST - t;
		end
		idx = 32'(bank) * 32'(PER_BANK) + 32'(t);
		tap_word = idx[ADDR_W-1:0];
	endfunction

	// Reset release in step with the main clock
	logic       rst_meta;
	logic       rst_n;
	always_ff @(posedge sys_clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			rst_meta <= 1'b0;
			rst_n    <= 1'b0;
		end else begin
			rst_meta <= 1'b1;
			rst_n    <= rst_meta;
		end
	end

	// ---------------- Coefficient port domain ----------------
	logic [COEFF_W-1:0] store [TOTAL];
	logic               we_prev;
	logic               done_toggle;
	fir_bank_pkg::coeff_wr_t wr_req;
	fir_bank_pkg::coeff_rd_t next_rd;
	wire                addr_ok;
	wire                write_hit;
	wire                reload_end;
	wire                reload_on;
	wire                write_on;
	wire                next_toggle;

	// Port features fixed at build time
	assign reload_on    = (RELOAD_EN != 0);
	assign write_on     = reload_on && (READ_WRITE != 0);

	// Write and read decode
	assign addr_ok      = addr_in_range(coeff_addr_in);
	assign wr_req.we    = write_on && coeff_we_in && addr_ok;
	assign wr_req.addr  = `FIR_CARRIER_ADDR_W'(coeff_addr_in);
	assign wr_req.data  = `FIR_CARRIER_DATA_W'(coeff_wdata_in);
	assign write_hit    = wr_req.we;
	assign next_rd.valid = reload_on && addr_ok && !coeff_we_in;
	assign next_rd.data = `FIR_CARRIER_DATA_W'(store[coeff_addr_in]);
	assign reload_end   = we_prev && !coeff_we_in && write_on;
	assign next_toggle  = done_toggle ^ reload_end;

	// Coefficient store, one word per write cycle
	always_ff @(posedge coeff_clk_in) begin
		if (write_hit) begin
			store[wr_req.addr[ADDR_W-1:0]] <= wr_req.data[COEFF_W-1:0];
		end
	end

	// Read valid registered one port cycle after the address
	always_ff @(posedge coeff_clk_in or posedge coeff_rst_in) begin
		if (coeff_rst_in) begin
			coeff_rvalid_out <= `FIR_RST_RVALID;
		end else begin
			coeff_rvalid_out <= next_rd.valid;
		end
	end

	// Read data, zero while not valid
	always_ff @(posedge coeff_clk_in or posedge coeff_rst_in) begin
		if (coeff_rst_in) begin
			coeff_rdata_out <= '0;
		end else begin
			coeff_rdata_out <= next_rd.valid ? next_rd.data[COEFF_W-1:0] : '0;
		end
	end

	// Write enable history for the end of burst
	always_ff @(posedge coeff_clk_in or posedge coeff_rst_in) begin
		if (coeff_rst_in) begin
			we_prev <= 1'b0;
		end else begin
			we_prev <= coeff_we_in;
		end
	end

	// End of reload flips a toggle for the filter domain
	always_ff @(posedge coeff_clk_in or posedge coeff_rst_in) begin
		if (coeff_rst_in) begin
			done_toggle <= `FIR_RST_TOGGLE;
		end else begin
			done_toggle <= next_toggle;
		end
	end

	// ---------------- Filter clock domain ----------------
	logic [2:0]         done_sync;
	logic [COEFF_W-1:0] shadow [TOTAL];
	wire                take_update;

	// Toggle synchroniser; first stage feeds only the second
	always_ff @(posedge sys_clk_in or negedge rst_n) begin
		if (!rst_n) begin
			done_sync <= `FIR_RST_SYNC;
		end else begin
			done_sync <= {done_sync[1:0], done_toggle};
		end
	end
	assign take_update = done_sync[2] ^ done_sync[1];

	// Stable store copied whole once the write burst has ended
	always_ff @(posedge sys_clk_in or negedge rst_n) begin
		if (!rst_n) begin
			for (int i = 0; i < TOTAL; i++) begin
				shadow[i] <= '0;
			end
		end else if (take_update) begin
			for (int i = 0; i < TOTAL; i++) begin
				shadow[i] <= store[i];
			end
		end
	end

	// Input FIFO; samples only enter on valid, so processing halts without it
	wire              fifo_in_ready;
	wire              drain_ready;
	wire [SINK_W-1:0] head;

	assign drain_ready    = (BACKPRESSURE != 0) ? out_ready_in : 1'b1;
	assign sink_ready_out = (BACKPRESSURE != 0) ? fifo_in_ready : 1'b1;

	stream_fifo #(
		.WIDTH (SINK_W),
		.DEPTH (FIFO_DEPTH)
	) u_fifo (
		.sys_clk_in    (sys_clk_in),
		.rst_n_in      (rst_n),
		.in_valid_in   (sink_valid_in),
		.in_ready_out  (fifo_in_ready),
		.in_data_in    (sink_data_in),
		.out_valid_out (out_valid_out),
		.out_ready_in  (drain_ready),
		.out_data_out  (head)
	);

	// Per-wire split of bank and sample, and coefficient lookup
	genvar w;
	generate
		for (w = 0; w < INPUT_WIRE_COUNT; w++) begin : g_wire
			wire [LANE_W-1:0]   lane;
			wire [BANK_W-1:0]   bank;
			wire [SAMPLE_W-1:0] sample;
			wire [ADDR_W-1:0]   tap_addr;

			// Wire 0 in the lowest slice, bank above sample
			assign lane   = head[w*LANE_W +: LANE_W];
			assign bank   = lane[LANE_W-1 -: BANK_W];
			assign sample = lane[SAMPLE_W-1:0];
			assign out_sample_out[w*SAMPLE_W +: SAMPLE_W] = sample;
			assign out_bank_out[w*BANK_W +: BANK_W]       = bank;

			// Bank taken from this very sample, per wire
			assign tap_addr = tap_word(bank, tap_index_in);
			assign tap_coeff_out[w*COEFF_W +: COEFF_W]    = shadow[tap_addr];
		end
	endgenerate
endmodule // fir_coeff_bank_reload

// >>> tb_fir_coeff_bank_reload.sv
// Self-checking bench: two wires, four banks, 37 symmetric taps.
// Assumes the package, the design, the checker and the master model compile first.
`timescale 1ns/10ps
module tb_fir_coeff_bank_reload;
	logic        sys_clk_in, nrst_in, sink_valid_in, sink_ready_out, out_valid_out, out_ready_in;
	logic [19:0] sink_data_in;
	logic [15:0] out_sample_out, cwd, crd, d;
	logic [3:0]  out_bank_out;
	logic [5:0]  tap_index_in;
	logic [31:0] tap_coeff_out;
	logic        cclk, crst, cwe, crv, v;
	logic [6:0]  caddr;
	int          fail_count, n_tests, a;
	int          ra[8] = '{0, 18, 19, 38, 56, 75, 76, 79};

	fir_coeff_bank_reload #(.INPUT_WIRE_COUNT(2)) dut (.sys_clk_in(sys_clk_in), .nrst_in(nrst_in),
		.sink_valid_in(sink_valid_in), .sink_ready_out(sink_ready_out), .sink_data_in(sink_data_in),
		.out_valid_out(out_valid_out), .out_ready_in(out_ready_in), .out_sample_out(out_sample_out),
		.out_bank_out(out_bank_out), .tap_index_in(tap_index_in), .tap_coeff_out(tap_coeff_out),
		.coeff_clk_in(cclk), .coeff_rst_in(crst), .coeff_addr_in(caddr), .coeff_wdata_in(cwd),
		.coeff_we_in(cwe), .coeff_rdata_out(crd), .coeff_rvalid_out(crv));
	coeff_master partner (.clk_out(cclk), .rst_out(crst), .addr_out(caddr), .wdata_out(cwd), .we_out(cwe),
		.rdata_in(crd), .rvalid_in(crv));

	// Main clock, 10 MHz
	initial begin
		sys_clk_in = 1'b0;
		forever #50 sys_clk_in = ~sys_clk_in;
	end

	// Hang guard
	initial begin
		#1000000;
		fail_count++;
		finish_test();
	end

	function automatic logic [15:0] cf(input int x);
		return 16'h0a00 + 16'(x);
	endfunction

	task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		n_tests++;
		if (seen !== exp) begin
			fail_count++;
			$display("wrong value %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	task automatic finish_test();
		if (fail_count == 0 && n_tests > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	// Bank above sample on each wire, wire 0 lowest
	task automatic push(input logic [1:0] b0, b1, input logic [7:0] s0, s1);
		@(negedge sys_clk_in);
		sink_valid_in = 1'b1;
		sink_data_in = {b1, s1, b0, s0};
	endtask

	task automatic idle();
		@(negedge sys_clk_in) sink_valid_in = 1'b0;
	endtask

	task automatic pop();
		@(negedge sys_clk_in) out_ready_in = 1'b1;
		@(negedge sys_clk_in) out_ready_in = 1'b0;
	endtask

	// Tap lookup on the head sample, mirrored taps folded
	task automatic chk_taps(input int b0, input int b1);
		int tp;
		for (int t = 0; t < 37; t += 6) begin
			tp = (t >= 19) ? 36 - t : t;
			tap_index_in = 6'(t);
			#1;
			check("tap_coeff", tap_coeff_out, {cf(b1 * 19 + tp), cf(b0 * 19 + tp)});
		end
	endtask

	// Test sequence
	initial begin
		fail_count = 0;
		n_tests = 0;
		nrst_in = 1'b0;
		sink_valid_in = 1'b0;
		sink_data_in = 20'h00000;
		out_ready_in = 1'b0;
		tap_index_in = 6'h00;
		repeat (8) @(negedge sys_clk_in);
		check("ready_rst", sink_ready_out, 1);
		check("valid_rst", out_valid_out, 0);
		check("coeff_rst", tap_coeff_out, 0);
		nrst_in = 1'b1;
		repeat (3) @(negedge sys_clk_in);
		partner.pulse_rst();
		for (int i = 0; i < 80; i++) partner.wr(7'(i), cf(i));
		partner.wr_end();
		for (int i = 0; i < 8; i++) begin
			a = ra[i];
			partner.rd(7'(a), d, v);
			check("rvalid", v, a < 76);
			check("rdata", d, a < 76 ? cf(a) : 0);
		end
		repeat (10) @(negedge sys_clk_in);
		for (int b = 0; b < 4; b++) begin
			push(2'(b), 2'(3 - b), 8'(b + 8'h40), 8'h9c);
			idle();
			check("sample", out_sample_out, {8'h9c, 8'(b + 8'h40)});
			check("bank", out_bank_out, {2'(3 - b), 2'(b)});
			chk_taps(b, 3 - b);
			pop();
		end
		partner.pulse_rst();
		partner.wr(7'd57, 16'h7777);
		partner.wr_end();
		repeat (12) @(negedge sys_clk_in);
		push(2'd3, 2'd0, 8'h01, 8'h02);
		idle();
		tap_index_in = 6'h00;
		#1;
		check("reload", tap_coeff_out, {cf(0), 16'h7777});
		pop();
		for (int i = 0; i < 32; i++) push(2'(i), 2'(~i), 8'(i), 8'(~i));
		idle();
		check("full", sink_ready_out, 0);
		out_ready_in = 1'b1;
		for (int i = 0; i < 32; i++) begin
			check("fifo", {out_valid_out, out_bank_out, out_sample_out}, {1'b1, 2'(~i), 2'(i), 8'(~i), 8'(i)});
			@(negedge sys_clk_in);
		end
		check("empty", out_valid_out, 0);
		finish_test();
	end
endmodule // tb_fir_coeff_bank_reload
